// file: core/alarm_defs.svh
// Field positions, reset values and timing counts of the alarm monitor
`ifndef ALARM_DEFS_SVH
`define ALARM_DEFS_SVH

// Alarm bit positions: major group
`define AL_SYNTH_UNLOCK 0
`define AL_SIGNAL 1
`define AL_BACKUP_FAIL 2
`define AL_NO_BACKUP 3
`define AL_POLLING 4
`define AL_RELAY 5
// Minor group
`define AL_LEARN 6
`define AL_BACKUP_TEST 7
`define AL_CONFIG_CHANGED 8
`define AL_RF_LEVEL 9
`define AL_IF_LEVEL 10
// Common group
`define AL_LOGIC_A 11
`define AL_LOGIC_B 12
`define AL_NVM 13
`define AL_EXT_REF 14
`define AL_CTRL_SUPPLY 15
`define AL_SUPPLY_P9 16
`define AL_SUPPLY_P15 17
`define AL_SUPPLY_N15 18
`define AL_COUNT 19

// Reset values
`define MASK_RESET 19'h00000
`define LATCHED_RESET 19'h00000

// Timing: clock rate and the times the counts derive from
`define CLK_HZ 125000000
`define FLASH_PERIOD_MS 1000
`define FLASH_CYCLES (`FLASH_PERIOD_MS * (`CLK_HZ / 1000))
`define REF_QUAL_US 10
`define REF_QUAL_CYCLES (`REF_QUAL_US * (`CLK_HZ / 1000000))
`define NVM_CHECK_MS 100
`define NVM_CHECK_CYCLES (`NVM_CHECK_MS * (`CLK_HZ / 1000))
`define POWERUP_CHECK_CYCLES 16

// Fault log geometry
`define LOG_DEPTH 32
`define STAMP_W 32

`endif

// file: core/alarm_pkg.sv
// Types shared by the alarm monitor and its fault log
package alarm_pkg;

   typedef logic [18:0] alarm_vec_t;

   // Supply rail in-range flags
   typedef struct packed {
      logic ctrl_5v;
      logic p9v;
      logic p15v;
      logic n15v;
   } supply_ok_s;

   // Backup-unit switch conditions
   typedef struct packed {
      logic process_fail;
      logic no_backup;
      logic polling_fail;
      logic relay_mismatch;
   } backup_cond_s;

   // One fault log entry
   typedef struct packed {
      logic [31:0] stamp;
      logic [4:0] alarm_id;
   } log_entry_s;

   // Learn and compatibility test sequence
   typedef enum logic [3:0] {
      LEARN_IDLE = 4'b0001,
      LEARN_CAPTURE = 4'b0010,
      LEARN_TEST = 4'b0100,
      LEARN_DONE = 4'b1000
   } learn_state_e;

endpackage

// file: core/converter_alarm_monitor.sv
// Converter alarm monitor: alarm collection, masking, latching, log and reference select
// Summary of operation
// - Valid external reference selects external source
// - Missing or bad reference falls back internal
// - Alarm status read-only, masks user writable
// - Masked failing alarm still reported, otherwise ignored
// - Synthesizer unlock raises major alarm
// - IF detect fault raises major signal alarm
// - Backup learn/test/config faults flash indicator 1s
// - Learn start runs compatibility test too
// - Compare prime settings against learned settings
// - RF and IF low levels raise minors
// - Power-up logic device readback check alarms
// - Memory readback checked at power-up, periodically
// - No external reference sets activity alarm
// - Each out-of-range supply rail alarms separately
// - Latched copy holds fail after recovery
// - Confirmed clear resets latched alarms no longer active
// - Every unmasked fault onset logged with time stamp while the log has room
// - Erase command empties the fault log
`timescale 1ns/1ns
`include "alarm_defs.svh"
module converter_alarm_monitor
   import alarm_pkg::*;
#(
   parameter int FLASH_CYCLES = `FLASH_CYCLES,
   parameter int NVM_CHECK_CYCLES = `NVM_CHECK_CYCLES,
   parameter int REF_QUAL_CYCLES = `REF_QUAL_CYCLES,
   parameter int LOG_DEPTH = `LOG_DEPTH,
   parameter int CONFIG_W = 32,
   parameter logic [7:0] LOGIC_A_EXPECT = 8'h5a,
   parameter logic [7:0] LOGIC_B_EXPECT = 8'ha5,
   parameter logic [7:0] NVM_EXPECT = 8'h3c
) (
   input wire logic clk,
   input wire logic rst_b,
   // Pins from outside the clock domain
   input wire logic synth_locked,
   input wire logic if_level_low,
   input wire logic rf_level_low,
   input wire logic ref_present,
   input wire logic ref_in_spec,
   input wire supply_ok_s supply_ok,
   input wire backup_cond_s backup_cond,
   input wire logic backup_strap,
   // Same-clock readback buses
   input wire logic [7:0] logic_a_readback,
   input wire logic [7:0] logic_b_readback,
   input wire logic [7:0] nvm_readback,
   // Processor side
   input wire alarm_vec_t alarm_mask,
   input wire logic clear_confirm,
   input wire logic learn_start,
   input wire logic learn_ok,
   input wire logic compat_ok,
   input wire logic [CONFIG_W-1:0] prime_config,
   input wire logic [`STAMP_W-1:0] time_stamp,
   input wire logic log_erase,
   input wire logic [$clog2(LOG_DEPTH)-1:0] log_rd_index,
   output alarm_vec_t active_alarm_set,
   output alarm_vec_t latched_alarm_set,
   output logic summary_fault,
   output logic ext_ref_select,
   output logic switch_fault_indicator,
   output logic backup_unit,
   output logic learn_busy,
   output log_entry_s log_rd_entry,
   output logic [$clog2(LOG_DEPTH):0] log_count,
   output logic log_overflow
);

   localparam int PIN_W = 14;
   localparam int FW = $clog2(FLASH_CYCLES + 1);
   localparam int NW = $clog2(NVM_CHECK_CYCLES + 1);
   localparam int QW = $clog2(REF_QUAL_CYCLES + 1);

   generate
      if (FLASH_CYCLES < 2 || NVM_CHECK_CYCLES < 2 || REF_QUAL_CYCLES < 1) begin : g_bad_cnt
         $error("converter_alarm_monitor counts too small");
      end
      if (CONFIG_W < 1) begin : g_bad_cfg
         $error("converter_alarm_monitor config width must be positive");
      end
   endgenerate

   // Lowest set bit as one-hot
   function automatic alarm_vec_t lowest_onehot(input alarm_vec_t v);
      lowest_onehot = v & (~v + 1'b1);
   endfunction

   // Index of the lowest set bit
   function automatic logic [4:0] lowest_index(input alarm_vec_t v);
      lowest_index = 5'h00;
      for (int i = `AL_COUNT - 1; i >= 0; i--) begin
         if (v[i]) begin
            lowest_index = 5'(i);
         end
      end
   endfunction

   // Two-stage synchroniser for all pin inputs
   logic [PIN_W-1:0] pin_meta;
   logic [PIN_W-1:0] pin_sync;
   wire logic [PIN_W-1:0] pin_raw = {synth_locked, if_level_low, rf_level_low, ref_present,
                                     ref_in_spec, supply_ok, backup_cond, backup_strap};

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pin_meta <= '0;
         pin_sync <= '0;
      end else begin
         pin_meta <= pin_raw;
         pin_sync <= pin_meta;
      end
   end

   // Named views of synchronised pins
   wire logic s_locked = pin_sync[13];
   wire logic s_if_low = pin_sync[12];
   wire logic s_rf_low = pin_sync[11];
   wire logic s_ref_present = pin_sync[10];
   wire logic s_ref_in_spec = pin_sync[9];
   wire supply_ok_s s_supply = pin_sync[8:5];
   wire backup_cond_s s_backup = pin_sync[4:1];
   wire logic s_strap = pin_sync[0];

   // Strap capture once synchroniser has filled after reset release
   logic [1:0] warmup;
   logic strap_taken;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         warmup <= 2'h0;
         strap_taken <= 1'b0;
         backup_unit <= 1'b0;
      end else begin
         if (warmup != 2'h3) begin
            warmup <= warmup + 2'h1;
         end
         if (warmup == 2'h3 && !strap_taken) begin
            strap_taken <= 1'b1;
            backup_unit <= s_strap;
         end
      end
   end

   // Reference qualification: autonomous, no processor input involved
   wire logic ref_good = s_ref_present && s_ref_in_spec;
   logic [QW-1:0] ref_qual;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ref_qual <= '0;
         ext_ref_select <= 1'b0;
      end else begin
         if (!ref_good) begin
            ref_qual <= '0;
            ext_ref_select <= 1'b0;
         end else if (ref_qual == QW'(REF_QUAL_CYCLES)) begin
            ext_ref_select <= 1'b1;
         end else begin
            ref_qual <= ref_qual + 1'b1;
         end
      end
   end

   // Learn and compatibility test sequence
   learn_state_e learn_state;
   learn_state_e next_learn_state;
   logic [CONFIG_W-1:0] learned_config;
   logic learned_valid;
   logic learn_fail;
   logic test_fail;

   always_comb begin
      next_learn_state = learn_state;
      case (learn_state)
         LEARN_IDLE: begin
            if (learn_start && backup_unit) begin
               next_learn_state = LEARN_CAPTURE;
            end
         end
         LEARN_CAPTURE: next_learn_state = LEARN_TEST;
         LEARN_TEST: next_learn_state = LEARN_DONE;
         LEARN_DONE: next_learn_state = LEARN_IDLE;
         default: next_learn_state = LEARN_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         learn_state <= LEARN_IDLE;
         learned_config <= '0;
         learned_valid <= 1'b0;
         learn_fail <= 1'b0;
         test_fail <= 1'b0;
         learn_busy <= 1'b0;
      end else begin
         learn_state <= next_learn_state;
         learn_busy <= next_learn_state != LEARN_IDLE;
         if (learn_state == LEARN_CAPTURE) begin
            learned_config <= prime_config;
            learned_valid <= learn_ok;
            learn_fail <= !learn_ok;
         end
         if (learn_state == LEARN_TEST) begin
            test_fail <= !compat_ok;
         end
      end
   end

   // Settings drift against what was learned
   wire logic config_drift = learned_valid && (prime_config != learned_config);

   // Power-up and periodic readback checks
   logic [4:0] powerup_cnt;
   logic powerup_done;
   logic logic_a_bad;
   logic logic_b_bad;
   logic nvm_bad;
   logic [NW-1:0] nvm_cnt;
   wire logic powerup_check = !powerup_done && powerup_cnt == 5'(`POWERUP_CHECK_CYCLES);
   wire logic nvm_period = powerup_done && nvm_cnt == NW'(NVM_CHECK_CYCLES - 1);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         powerup_cnt <= 5'h00;
         powerup_done <= 1'b0;
         logic_a_bad <= 1'b0;
         logic_b_bad <= 1'b0;
         nvm_bad <= 1'b0;
         nvm_cnt <= '0;
      end else begin
         if (!powerup_done) begin
            powerup_cnt <= powerup_cnt + 5'h01;
         end
         if (powerup_check) begin
            powerup_done <= 1'b1;
            logic_a_bad <= logic_a_readback != LOGIC_A_EXPECT;
            logic_b_bad <= logic_b_readback != LOGIC_B_EXPECT;
         end
         if (powerup_check || nvm_period) begin
            nvm_bad <= nvm_readback != NVM_EXPECT;
         end
         nvm_cnt <= (!powerup_done || nvm_period) ? '0 : nvm_cnt + 1'b1;
      end
   end

   // Raw alarm conditions, gathered by group
   alarm_vec_t next_active;
   wire logic bk = backup_unit;

   always_comb begin
      next_active = '0;
      next_active[`AL_SYNTH_UNLOCK] = !s_locked;
      next_active[`AL_SIGNAL] = s_if_low;
      next_active[`AL_BACKUP_FAIL] = bk && s_backup.process_fail;
      next_active[`AL_NO_BACKUP] = bk && s_backup.no_backup;
      next_active[`AL_POLLING] = bk && s_backup.polling_fail;
      next_active[`AL_RELAY] = bk && s_backup.relay_mismatch;
      next_active[`AL_LEARN] = bk && learn_fail;
      next_active[`AL_BACKUP_TEST] = bk && test_fail;
      next_active[`AL_CONFIG_CHANGED] = bk && config_drift;
      next_active[`AL_RF_LEVEL] = s_rf_low;
      next_active[`AL_IF_LEVEL] = s_if_low;
      next_active[`AL_LOGIC_A] = logic_a_bad;
      next_active[`AL_LOGIC_B] = logic_b_bad;
      next_active[`AL_NVM] = nvm_bad;
      next_active[`AL_EXT_REF] = !s_ref_present;
      next_active[`AL_CTRL_SUPPLY] = !s_supply.ctrl_5v;
      next_active[`AL_SUPPLY_P9] = !s_supply.p9v;
      next_active[`AL_SUPPLY_P15] = !s_supply.p15v;
      next_active[`AL_SUPPLY_N15] = !s_supply.n15v;
   end

   // Masking affects only responses, never the reported status
   wire alarm_vec_t unmasked_next = next_active & ~alarm_mask;
   wire alarm_vec_t next_latched = clear_confirm ? next_active
                                                 : (latched_alarm_set | next_active);
   wire logic flash_cause = unmasked_next[`AL_LEARN] || unmasked_next[`AL_BACKUP_TEST]
                            || unmasked_next[`AL_CONFIG_CHANGED];

   // Active, latched and summary status
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         active_alarm_set <= '0;
         latched_alarm_set <= `LATCHED_RESET;
         summary_fault <= 1'b0;
      end else begin
         active_alarm_set <= next_active;
         latched_alarm_set <= next_latched;
         summary_fault <= |unmasked_next;
      end
   end

   // Switch fault indicator flashing at the set interval
   logic [FW-1:0] flash_cnt;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         flash_cnt <= '0;
         switch_fault_indicator <= 1'b0;
      end else if (!flash_cause) begin
         flash_cnt <= '0;
         switch_fault_indicator <= 1'b0;
      end else if (flash_cnt == FW'(FLASH_CYCLES - 1)) begin
         flash_cnt <= '0;
         switch_fault_indicator <= !switch_fault_indicator;
      end else begin
         flash_cnt <= flash_cnt + 1'b1;
      end
   end

   // New fault onsets queue one per cycle into the log
   alarm_vec_t prev_active;
   alarm_vec_t pending;
   wire alarm_vec_t onset = next_active & ~prev_active & ~alarm_mask;
   wire alarm_vec_t grant = lowest_onehot(pending);
   wire logic log_wr = |pending;
   log_entry_s log_entry;

   always_comb begin
      log_entry.stamp = time_stamp;
      log_entry.alarm_id = lowest_index(pending);
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         prev_active <= '0;
         pending <= '0;
      end else begin
         prev_active <= next_active;
         pending <= (pending & ~grant) | onset;
      end
   end

   // Log store; start-up faults included since onsets count from reset
   fault_log #(
      .DEPTH(LOG_DEPTH)
   ) u_log (
      .clk(clk),
      .rst_b(rst_b),
      .wr_valid(log_wr),
      .wr_entry(log_entry),
      .erase(log_erase),
      .rd_index(log_rd_index),
      .rd_entry(log_rd_entry),
      .count(log_count),
      .overflow(log_overflow)
   );

endmodule

// file: core/fault_log.sv
// Time-stamped fault log store with erase
`timescale 1ns/1ns
`include "alarm_defs.svh"
module fault_log
   import alarm_pkg::*;
#(
   parameter int DEPTH = `LOG_DEPTH
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic wr_valid,
   input wire log_entry_s wr_entry,
   input wire logic erase,
   input wire logic [$clog2(DEPTH)-1:0] rd_index,
   output log_entry_s rd_entry,
   output logic [$clog2(DEPTH):0] count,
   output logic overflow
);

   localparam int AW = $clog2(DEPTH);

   generate
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
         $error("fault_log depth must be a power of two, at least 2");
      end
   endgenerate

   log_entry_s store [DEPTH];

   // Space left after an erase in the same cycle
   wire logic [AW:0] base_count = erase ? '0 : count;
   wire logic is_full = base_count == (AW+1)'(DEPTH);
   wire logic do_write = wr_valid && !is_full;
   wire logic [AW-1:0] wr_addr = base_count[AW-1:0];

   // Entry storage, no reset needed on the array
   always_ff @(posedge clk) begin
      if (do_write) begin
         store[wr_addr] <= wr_entry;
      end
   end

   // Fill count and overflow flag; a write in the erase cycle is kept
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         count <= '0;
         overflow <= 1'b0;
         rd_entry <= '0;
      end else begin
         count <= do_write ? base_count + 1'b1 : base_count;
         overflow <= (overflow && !erase) || (wr_valid && is_full);
         rd_entry <= store[rd_index];
      end
   end

endmodule

// file: testbench/converter_alarm_monitor_monitor.sv
// Port checker for the converter alarm monitor, bound to the top module
`timescale 1ns/1ns
module converter_alarm_monitor_chk
   import alarm_pkg::*;
#(
   parameter int LOG_DEPTH = 32
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic synth_locked,
   input wire logic if_level_low,
   input wire logic ref_present,
   input wire logic ref_in_spec,
   input wire supply_ok_s supply_ok,
   input wire alarm_vec_t alarm_mask,
   input wire logic clear_confirm,
   input wire logic learn_start,
   input wire logic log_erase,
   input wire alarm_vec_t active_alarm_set,
   input wire alarm_vec_t latched_alarm_set,
   input wire logic summary_fault,
   input wire logic ext_ref_select,
   input wire logic switch_fault_indicator,
   input wire logic backup_unit,
   input wire logic learn_busy,
   input wire logic [$clog2(LOG_DEPTH):0] log_count
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);

   // Learn request accepted, then three busy cycles and back to idle
   sequence learn_taken;
      learn_start && !learn_busy && backup_unit;
   endsequence
   sequence learn_run;
      learn_busy [*3] ##1 !learn_busy;
   endsequence

   // Pin faults reach the active set within the sync delay
   chk_synth_unlock: assert property ((!synth_locked) [*4] |-> active_alarm_set[0])
      else $error("synth unlock alarm missing");
   chk_if_level: assert property (if_level_low [*4] |-> active_alarm_set[1] && active_alarm_set[10])
      else $error("if level alarms missing");
   chk_ref_absent: assert property ((!ref_present) [*4] |-> active_alarm_set[14] && !ext_ref_select)
      else $error("absent reference not handled");
   chk_ref_good: assert property ((ref_present && ref_in_spec) [*8] |-> ext_ref_select)
      else $error("good reference not selected");
   chk_supply_rails: assert property ($stable(supply_ok) [*4] |->
      active_alarm_set[18:15] == ~{supply_ok.n15v, supply_ok.p15v, supply_ok.p9v, supply_ok.ctrl_5v})
      else $error("supply alarms wrong");
   // Latched set covers active, holds, and follows a clear
   chk_latch_cover: assert property ((active_alarm_set & ~latched_alarm_set) == '0)
      else $error("active alarm not latched");
   chk_latch_sticky: assert property (!$past(clear_confirm) |->
      ($past(latched_alarm_set) & ~latched_alarm_set) == '0)
      else $error("latched alarm dropped without clear");
   chk_clear_exact: assert property (clear_confirm |=> latched_alarm_set == active_alarm_set)
      else $error("clear result wrong");
   chk_summary_or: assert property (($stable(alarm_mask) && $stable(active_alarm_set)) [*2] |->
      summary_fault == |(active_alarm_set & ~alarm_mask))
      else $error("summary flag wrong");
   chk_learn_seq: assert property (learn_taken |=> learn_run)
      else $error("learn sequence length wrong");
   chk_backup_gate: assert property ((!backup_unit) [*4] |-> active_alarm_set[8:2] == '0)
      else $error("backup alarm on prime unit");
   chk_flash_off: assert property (((active_alarm_set[8:6] & ~alarm_mask[8:6]) == 3'h0) [*3] |->
      !switch_fault_indicator)
      else $error("indicator on without cause");
   chk_log_erase: assert property (log_erase |=> log_count <= 1)
      else $error("log not emptied");
endmodule

bind converter_alarm_monitor converter_alarm_monitor_chk #(.LOG_DEPTH(LOG_DEPTH)) u_chk (
   .clk(clk), .rst_b(rst_b), .synth_locked(synth_locked), .if_level_low(if_level_low),
   .ref_present(ref_present), .ref_in_spec(ref_in_spec), .supply_ok(supply_ok),
   .alarm_mask(alarm_mask), .clear_confirm(clear_confirm), .learn_start(learn_start),
   .log_erase(log_erase), .active_alarm_set(active_alarm_set),
   .latched_alarm_set(latched_alarm_set), .summary_fault(summary_fault),
   .ext_ref_select(ext_ref_select), .switch_fault_indicator(switch_fault_indicator),
   .backup_unit(backup_unit), .learn_busy(learn_busy), .log_count(log_count));

// file: testbench/converter_alarm_monitor_tb_top.sv
// Self-checking bench for the converter alarm monitor
`timescale 1ns/1ns
module converter_alarm_monitor_tb_top;
   import alarm_pkg::*;
   typedef struct {int kind; logic [36:0] val;} note_s;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [11:0] fw = 12'h000;
   logic strap = 1'b1;
   logic ref_spec = 1'b1;
   logic [7:0] pld_a = 8'h5a;
   logic [7:0] nvm = 8'h3c;
   logic [31:0] r;
   int seed = 8;
   int bad_count = 0;
   int tests_run = 0;
   int tgl = 0;
   logic ind_q = 1'b0;
   note_s notes[$];
   event take;
   alarm_vec_t active_alarm_set, latched_alarm_set, alarm_mask, m, e;
   logic summary_fault, ext_ref_select, switch_fault_indicator, backup_unit, learn_busy;
   logic clear_confirm, learn_start, learn_ok, compat_ok, log_erase, log_overflow;
   logic [31:0] prime_config, time_stamp;
   logic [4:0] log_rd_index;
   log_entry_s log_rd_entry;
   logic [5:0] log_count;

   always #4 clk = ~clk;

   mc_processor_model u_mc_processor_model (.clk(clk), .alarm_mask(alarm_mask),
      .clear_confirm(clear_confirm), .learn_start(learn_start), .learn_ok(learn_ok),
      .compat_ok(compat_ok), .prime_config(prime_config), .time_stamp(time_stamp),
      .log_erase(log_erase), .log_rd_index(log_rd_index));

   converter_alarm_monitor #(.FLASH_CYCLES(8), .NVM_CHECK_CYCLES(16), .REF_QUAL_CYCLES(4))
      u_converter_alarm_monitor (.clk(clk), .rst_b(rst_b), .synth_locked(!fw[0]),
      .if_level_low(fw[1]), .rf_level_low(fw[2]), .ref_present(!fw[3]), .ref_in_spec(ref_spec),
      .supply_ok(~fw[7:4]), .backup_cond(fw[11:8]), .backup_strap(strap),
      .logic_a_readback(pld_a), .logic_b_readback(~pld_a), .nvm_readback(nvm),
      .alarm_mask(alarm_mask), .clear_confirm(clear_confirm), .learn_start(learn_start),
      .learn_ok(learn_ok), .compat_ok(compat_ok), .prime_config(prime_config),
      .time_stamp(time_stamp), .log_erase(log_erase), .log_rd_index(log_rd_index),
      .active_alarm_set(active_alarm_set), .latched_alarm_set(latched_alarm_set),
      .summary_fault(summary_fault), .ext_ref_select(ext_ref_select),
      .switch_fault_indicator(switch_fault_indicator), .backup_unit(backup_unit),
      .learn_busy(learn_busy), .log_rd_entry(log_rd_entry), .log_count(log_count),
      .log_overflow(log_overflow));

   // Expected active set for a fault word
   function automatic alarm_vec_t exp_of(input logic [11:0] f);
      alarm_vec_t v;
      v = '0;
      v[0] = f[0];
      v[1] = f[1];
      v[10] = f[1];
      v[9] = f[2];
      v[14] = f[3];
      v[18:15] = {f[4], f[5], f[6], f[7]};
      if (strap)
         v[5:2] = {f[8], f[9], f[10], f[11]};
      return v;
   endfunction

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   // Driver side: record an expectation for the watcher
   task automatic note(input int k, input logic [36:0] v);
      notes.push_back('{k, v});
      -> take;
   endtask
   task automatic cmp_vec(input alarm_vec_t exp, input alarm_vec_t got);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %0t alarm set exp %h got %h", $time, exp, got);
      end
   endtask
   task automatic cmp_val(input logic [36:0] exp, input logic [36:0] got);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %0t value exp %h got %h", $time, exp, got);
      end
   endtask
   task automatic summarize();
      if (bad_count == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Indicator toggle counter
   always @(posedge clk) begin
      if (switch_fault_indicator !== ind_q)
         tgl++;
      ind_q = switch_fault_indicator;
   end

   // Watcher: oldest note against the output it names
   always @(take) begin
      note_s n;
      while (notes.size() > 0) begin
         n = notes.pop_front();
         case (n.kind)
            0: cmp_vec(n.val[18:0], active_alarm_set);
            1: cmp_vec(n.val[18:0], latched_alarm_set);
            2: cmp_val(n.val, 37'(summary_fault));
            3: cmp_val(n.val, 37'(ext_ref_select));
            4: cmp_val(n.val, 37'({log_overflow, log_count}));
            5: cmp_val(n.val, log_rd_entry);
            6: cmp_val(n.val, 37'(tgl));
            default: cmp_val(n.val, 37'(learn_busy));
         endcase
      end
   end

   initial begin
      #100000;
      bad_count++;
      summarize();
   end

   initial begin
      cyc(6);
      note(0, '0);
      note(1, '0);
      cyc(6);
      rst_b = 1'b1;
      cyc(24);
      u_mc_processor_model.press(0);
      note(1, '0);
      note(3, 1);
      // Single faults, then random faults under random masks
      for (int i = 0; i < 24; i++) begin
         m = (i < 12) ? '0 : 19'($random(seed));
         r = $random(seed);
         pld_a = r[15:8];
         u_mc_processor_model.set(m, r[0], r[1], r, r[4:0]);
         fw = (i < 12) ? 12'h001 << i : 12'($random(seed));
         e = exp_of(fw);
         cyc(6);
         note(0, e);
         note(2, 37'(|(e & ~m)));
         u_mc_processor_model.press(0);
         note(1, e);
         note(3, 37'(!fw[3]));
         fw = 12'h000;
         cyc(10);
         note(1, e);
         note(3, 1);
         u_mc_processor_model.press(0);
         note(1, '0);
      end
      // Out-of-spec reference falls back to internal
      ref_spec = 1'b0;
      cyc(10);
      note(3, 0);
      ref_spec = 1'b1;
      cyc(12);
      note(3, 1);
      // Sixteen more onsets overflow the full log
      repeat (32) begin
         fw[2] = !fw[2];
         cyc(4);
      end
      note(4, 37'h60);
      // Log: erase, masked fault skipped, unmasked fault stamped
      u_mc_processor_model.set('0, 1'b1, 1'b1, 32'h0, 5'h00);
      u_mc_processor_model.press(2);
      cyc(2);
      note(4, 0);
      u_mc_processor_model.set(19'h00001, 1'b1, 1'b1, 32'h0, 5'h00);
      fw = 12'h001;
      cyc(8);
      note(4, 0);
      note(0, 19'h00001);
      fw = 12'h000;
      cyc(6);
      u_mc_processor_model.set('0, 1'b1, 1'b1, 32'h0, 5'h00);
      fw = 12'h004;
      cyc(8);
      note(4, 1);
      note(5, {32'hffff_ffff, 5'd9});
      fw = 12'h000;
      cyc(6);
      // Learn failure, test failure with flashing, mask, config change
      u_mc_processor_model.set('0, 1'b0, 1'b1, 32'h0000_00a5, 5'h00);
      u_mc_processor_model.press(1);
      cyc(8);
      note(0, 19'h00040);
      u_mc_processor_model.set('0, 1'b1, 1'b0, 32'h0000_00a5, 5'h00);
      u_mc_processor_model.press(1);
      cyc(8);
      note(0, 19'h00080);
      tgl = 0;
      cyc(32);
      note(6, 4);
      u_mc_processor_model.set(19'h00080, 1'b1, 1'b0, 32'h0000_00a5, 5'h00);
      cyc(4);
      tgl = 0;
      cyc(16);
      note(6, 0);
      note(0, 19'h00080);
      u_mc_processor_model.set('0, 1'b1, 1'b1, 32'h0000_00a5, 5'h00);
      u_mc_processor_model.press(1);
      cyc(8);
      note(0, 0);
      u_mc_processor_model.set('0, 1'b1, 1'b1, 32'h0000_005a, 5'h00);
      cyc(6);
      note(0, 19'h00100);
      // Periodic memory readback
      u_mc_processor_model.set('0, 1'b1, 1'b1, 32'h0000_00a5, 5'h00);
      nvm = 8'h00;
      cyc(40);
      note(0, 19'h02000);
      nvm = 8'h3c;
      cyc(40);
      note(0, 0);
      // Second reset as a prime unit with bad readbacks from both logic devices
      rst_b = 1'b0;
      strap = 1'b0;
      pld_a = 8'h00;
      fw = 12'hf00;
      cyc(12);
      rst_b = 1'b1;
      cyc(24);
      note(0, 19'h01800);
      u_mc_processor_model.press(1);
      note(7, 0);
      cyc(2);
      summarize();
   end
endmodule

// file: testbench/mc_processor_model.sv
// Processor and front panel model: masks, learn inputs and commands
`timescale 1ns/1ns
module mc_processor_model
   import alarm_pkg::*;
(
   input wire logic clk,
   output alarm_vec_t alarm_mask,
   output logic clear_confirm,
   output logic learn_start,
   output logic learn_ok,
   output logic compat_ok,
   output logic [31:0] prime_config,
   output logic [31:0] time_stamp,
   output logic log_erase,
   output logic [4:0] log_rd_index
);
   // Quiet panel at power up
   initial begin
      alarm_mask = '0;
      {clear_confirm, learn_start, log_erase, learn_ok, compat_ok} = 5'h00;
      prime_config = 32'h0000_0000;
      time_stamp = 32'h0000_1234;
      log_rd_index = 5'h00;
   end
   // Settings change on the falling edge
   task automatic set(input alarm_vec_t m, input logic lok, input logic cok,
                      input logic [31:0] cfg, input logic [4:0] idx);
      @(negedge clk);
      alarm_mask = m;
      learn_ok = lok;
      compat_ok = cok;
      prime_config = cfg;
      time_stamp = ~cfg;
      log_rd_index = idx;
   endtask
   // One-cycle command: 0 clear, 1 learn, 2 erase
   task automatic press(input int which);
      @(negedge clk);
      clear_confirm = (which == 0);
      learn_start = (which == 1);
      log_erase = (which == 2);
      @(negedge clk);
      {clear_confirm, learn_start, log_erase} = 3'h0;
   endtask
endmodule
